// ==== common/mrps_params.svh ====
// Constants of the multi-rail power sequencer: offsets, fields, timing.
// Assumes a 100 MHz pclk and a 32-bit APB register bus.
// Behaviour
// - Up to ten rails, each switched by its own enable output.
// - Sequence-on starts from control line pin or OPERATION on command.
// - Pin-only trigger: pin assertion sequences on, deassertion sequences off.
// - Auto-enable ignores command and pin; rails start once dependencies met.
// - Monitored rail good above power-good-on, until below power-good-off.
// - Unmonitored rail good after turn-on delay plus max turn-on time.
// - Unmonitored rail off after turn-off delay plus off warn time.
// - Monitor-only rail is never driven on.
// - Rail enables a set time after its enabled on-triggers all hold.
// - Turn-on and turn-off delays are limited to 3276 ms.
// - Command off or pin deassertion disables after delay; not monitor-only.
// - Parent rails falling or input pin level disable after delay.
// - Undervoltage, overvoltage or max turn-on fault turns rail off.
// - Fault-shutdown slave turns off after delay when master faults.
// - Max turn-on time in 1 ms steps; zero disables the limit.
// - Each rail either switches off at once or sequences off.
// - Turn-off delay starts on pin release, soft-stop or master fault.
// - Rail shutdown cascades to other rails; fault shutdown also to other controllers.
`ifndef MRPS_PARAMS_SVH
`define MRPS_PARAMS_SVH

// Timing
`define MRPS_CLK_HZ       100000000
`define MRPS_TICK_MS      1
`define MRPS_TICK_CYCLES  (`MRPS_CLK_HZ / 1000 * `MRPS_TICK_MS)
`define MRPS_DLY_MAX_MS   12'hCCC
`define MRPS_NUM_RAILS    10

// Global register byte offsets
`define MRPS_OFF_CTRL      12'h000
`define MRPS_OFF_RAIL_EN   12'h004
`define MRPS_OFF_RAIL_GOOD 12'h008
`define MRPS_OFF_TON_FAULT 12'h00C

// Rail block: byte address 0x100 + rail * 0x10 + word * 4
`define MRPS_RAIL_PAGE    4'h1
`define MRPS_W_CFG        2'h0
`define MRPS_W_PARENT     2'h1
`define MRPS_W_DELAY      2'h2
`define MRPS_W_LIMIT      2'h3

// Control register fields and reset values
`define MRPS_CTRL_OP_ON   0
`define MRPS_CTRL_AUTO    1
`define MRPS_CTRL_PIN_LOW 2
`define MRPS_CTRL_RST     3'h0
`define MRPS_WORD_RST     32'h0000_0000

`endif

// ==== common/mrps_pkg.sv ====
// Types of the multi-rail power sequencer.
// Assumes nothing of its surroundings.
package mrps_pkg;

  // Rail sequencing states
  typedef enum logic [1:0] {
    st_off      = 2'b00,
    st_on_wait  = 2'b01,
    st_on       = 2'b10,
    st_off_wait = 2'b11
  } mrps_state_t;

  // Per-rail configuration word
  typedef struct packed {
    logic [8:0] rsvd;
    logic       casc_out;
    logic       casc_in;
    logic       gpi_off_lvl;
    logic       gpi_on_lvl;
    logic [2:0] gpi_sel;
    logic [3:0] master;
    logic       slave;
    logic       immediate;
    logic       off_gpi;
    logic       off_parent;
    logic       off_pin;
    logic       off_op;
    logic       on_gpi;
    logic       on_parent;
    logic       on_pin;
    logic       on_op;
    logic       monitor_only;
    logic       monitored;
  } mrps_cfg_t;

  // Two 12-bit millisecond fields in one word
  typedef struct packed {
    logic [3:0]  rsvd_hi;
    logic [11:0] hi;
    logic [3:0]  rsvd_lo;
    logic [11:0] lo;
  } mrps_pair_t;

  // Parent rail masks: on mask low, off mask high
  typedef struct packed {
    logic [5:0] rsvd_hi;
    logic [9:0] off_mask;
    logic [5:0] rsvd_lo;
    logic [9:0] on_mask;
  } mrps_mask_t;

endpackage

// ==== verif/mrps_seq_sva.sv ====
// Port checker for the sequencer: APB answers and rail enables.
// Assumes it is bound into every mrps_sequencer instance.
`timescale 1ns/1ps
module mrps_seq_sva #(
  parameter int N_RAILS = 10
) (
  // Clock and reset
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               clk_en,
  // APB slave side
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [11:0]        paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  // Rail enables
  input wire logic [N_RAILS-1:0] rail_enable
);
  // Address decode of the finished transfer
  wire rd_done = pready && psel && !pwrite;
  wire in_rail = paddr[11:8] == 4'h1 && paddr[7:4] < N_RAILS;
  wire mapped  = paddr[11:4] == 8'h00 || in_rail;
  wire cfg_wr  = pready && psel && pwrite && in_rail && paddr[3:0] == 4'h0;

  logic [N_RAILS-1:0] mon_only;
  logic [N_RAILS-1:0] en_d1;
  logic [N_RAILS-1:0] en_d2;

  // Shadow of monitor-only bits, delayed enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_only <= '0;
      en_d1    <= '0;
      en_d2    <= '0;
    end else begin
      en_d1 <= rail_enable;
      en_d2 <= en_d1;
      if (cfg_wr) begin
        mon_only[paddr[7:4]] <= pwdata[1];
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_apb_answer: assert property (
    psel && penable && !pready && clk_en |=> pready)
    else $error("APB answer missing one cycle after access");
  a_ready_pulse: assert property (pready && clk_en |=> !pready)
    else $error("pready held longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_idle_data: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside the answer cycle");
  a_map_err: assert property (
    pready && paddr[1:0] == 2'b00 |-> pslverr == !mapped)
    else $error("error response does not match address map");
  a_delay_clamp: assert property (
    rd_done && in_rail && paddr[3:0] == 4'h8 |->
      prdata[11:0] <= 12'hCCC && prdata[27:16] <= 12'hCCC)
    else $error("delay read back above limit");
  a_fault_rsvd: assert property (
    rd_done && paddr == 12'h00C |-> (prdata >> N_RAILS) == 32'h0)
    else $error("turn-on fault flags beyond rail count");
  a_en_read: assert property (
    rd_done && paddr == 12'h004 && en_d1 == rail_enable &&
      en_d2 == en_d1 |-> prdata == 32'(rail_enable))
    else $error("enable register differs from enable outputs");
  a_mon_never: assert property (
    (rail_enable & ~en_d1 & mon_only) == '0)
    else $error("monitor-only rail switched on");
  a_freeze_en: assert property (
    !clk_en |=> $stable(rail_enable) && $stable(pready))
    else $error("state moved while clock enable low");
endmodule

bind mrps_sequencer mrps_seq_sva #(.N_RAILS(N_RAILS)) u_mrps_seq_sva (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rail_enable(rail_enable));

// ==== verif/mrps_supply_model.sv ====
// Supply model: each rail ramps up while enabled and not stuck, down otherwise.
// Assumes the sequencer synchronises the comparator levels.
`timescale 1ns/1ps
module mrps_supply_model #(
  parameter int N_RAILS = 10,
  parameter int RAMP    = 5
) (
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // Enables, and rails the bench keeps from rising
  input  wire logic [N_RAILS-1:0] rail_enable,
  input  wire logic [N_RAILS-1:0] stuck,
  // Comparator levels
  output logic      [N_RAILS-1:0] rail_above_on,
  output logic      [N_RAILS-1:0] rail_below_off
);
  int lvl [N_RAILS];

  // Ramp position per rail, 0 is discharged
  always_ff @(posedge pclk or negedge presetn) begin
    for (int i = 0; i < N_RAILS; i++) begin
      if (!presetn) begin
        lvl[i] <= 0;
      end else if (rail_enable[i] && !stuck[i]) begin
        lvl[i] <= (lvl[i] < RAMP) ? lvl[i] + 1 : RAMP;
      end else begin
        lvl[i] <= (lvl[i] > 0) ? lvl[i] - 1 : 0;
      end
    end
  end

  // Hysteresis: good only at the top, below off only at the bottom
  always_comb begin
    for (int i = 0; i < N_RAILS; i++) begin
      rail_above_on[i]  = lvl[i] == RAMP;
      rail_below_off[i] = lvl[i] == 0;
    end
  end
endmodule

// ==== verif/tb.sv ====
// Bench for the sequencer: APB master, supply model, rail scenarios.
// Assumes a ten-cycle millisecond tick for short runs.
`timescale 1ns/1ps
`include "mrps_params.svh"
module tb;
  localparam int TK = 10;
  logic        pclk = 1'b0;
  logic        presetn, clk_en, psel, penable, pwrite, control_line_pin;
  logic        cascade_in, pready, pslverr, cascade_out;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  general_input_pin;
  logic [9:0]  rail_above_on, rail_below_off, rail_uv_fault;
  logic [9:0]  rail_ov_fault, rail_enable, stuck;
  int          err_count = 0;
  int          check_count = 0;

  mrps_sequencer #(.TICK_CYCLES(TK)) u_mrps_sequencer (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .control_line_pin(control_line_pin),
    .general_input_pin(general_input_pin), .rail_above_on(rail_above_on),
    .rail_below_off(rail_below_off), .rail_uv_fault(rail_uv_fault),
    .rail_ov_fault(rail_ov_fault), .cascade_in(cascade_in),
    .rail_enable(rail_enable), .cascade_out(cascade_out));

  mrps_supply_model u_mrps_supply_model (
    .pclk(pclk), .presetn(presetn), .rail_enable(rail_enable),
    .stuck(stuck), .rail_above_on(rail_above_on),
    .rail_below_off(rail_below_off));

  // Clock
  always #5 pclk = ~pclk;

  task automatic chk(input string s, input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", s, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // One APB transfer, held until pready is sampled
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_count++;
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd_chk(input string s, input logic [11:0] a,
                        input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(s, q, x);
  endtask

  function automatic logic [11:0] ra(input int r, input int w);
    return 12'h100 + 12'(r * 16 + w * 4);
  endfunction

  // Bounded wait for one enable level, counting edges
  task automatic wait_en(input int r, input logic v, input int lim,
                         output int n);
    n = 0;
    while (rail_enable[r] !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (rail_enable[r] !== v) begin
      err_count++;
      $display("ERROR rail %0d expected %b seen %b", r, v, rail_enable[r]);
      report_and_stop();
    end
  endtask

  task automatic t_reset();
    logic [31:0] q;
    logic        e;
    clk_en <= 1'b0;
    repeat (3) @(posedge pclk);
    clk_en <= 1'b1;
    chk("enables", 32'(rail_enable), 32'h0);
    rd_chk("ctrl", `MRPS_OFF_CTRL, 32'h0);
    rd_chk("rail_en", `MRPS_OFF_RAIL_EN, 32'h0);
    rd_chk("ton_fault", `MRPS_OFF_TON_FAULT, 32'h0);
    apb(1'b0, 12'h080, 32'h0, q, e);
    chk("unmapped", 32'(e), 32'h1);
    wr(ra(6, 2), 32'h0FFF_0FFF);
    rd_chk("delay", ra(6, 2), 32'h0CCC_0CCC);
    $display("reset test done");
  endtask

  task automatic t_pin();
    int n;
    wr(ra(2, 0), 32'h0000_0088);
    wr(ra(2, 2), 32'h0001_0001);
    control_line_pin <= 1'b1;
    wait_en(2, 1'b1, 40, n);
    chk("pin on", 32'(n >= 10), 32'h1);
    rd_chk("good on", `MRPS_OFF_RAIL_GOOD, 32'h4);
    control_line_pin <= 1'b0;
    wait_en(2, 1'b0, 40, n);
    chk("pin off", 32'(n >= 10), 32'h1);
    rd_chk("good off", `MRPS_OFF_RAIL_GOOD, 32'h0);
    $display("pin test done");
  endtask

  task automatic t_op();
    int n;
    wr(ra(0, 0), 32'h0000_0045);
    wr(ra(0, 2), 32'h0002_0003);
    wr(ra(1, 0), 32'h0000_0007);
    wr(ra(3, 0), 32'h0000_0111);
    wr(ra(3, 1), 32'h0001_0001);
    wr(ra(3, 2), 32'h0001_0001);
    wr(`MRPS_OFF_CTRL, 32'h1);
    wait_en(0, 1'b1, 60, n);
    chk("op on", 32'(n >= 29 && n <= 46), 32'h1);
    wait_en(3, 1'b1, 60, n);
    chk("parent on", 32'(n >= 10), 32'h1);
    chk("monitor only", 32'(rail_enable[1]), 32'h0);
    rd_chk("rail_en", `MRPS_OFF_RAIL_EN, 32'h9);
    wr(`MRPS_OFF_CTRL, 32'h0);
    wait_en(0, 1'b0, 60, n);
    chk("op off", 32'(n >= 19 && n <= 36), 32'h1);
    wait_en(3, 1'b0, 60, n);
    chk("parent off", 32'(n >= 10), 32'h1);
    $display("operation test done");
  endtask

  task automatic t_fault();
    int n;
    stuck[4] <= 1'b1;
    wr(ra(4, 0), 32'h0040_0405);
    wr(ra(4, 3), 32'h0000_0002);
    wr(ra(5, 0), 32'h0000_4C05);
    wr(`MRPS_OFF_CTRL, 32'h1);
    wait_en(5, 1'b1, 40, n);
    wait_en(4, 1'b0, 60, n);
    chk("ton limit", 32'(n >= 15), 32'h1);
    chk("cascade out", 32'(cascade_out), 32'h1);
    wait_en(5, 1'b0, 20, n);
    chk("slave off", 32'(rail_enable[5]), 32'h0);
    rd_chk("ton_fault", `MRPS_OFF_TON_FAULT, 32'h10);
    wr(`MRPS_OFF_TON_FAULT, 32'h10);
    rd_chk("fault clear", `MRPS_OFF_TON_FAULT, 32'h0);
    wait_en(0, 1'b1, 60, n);
    rail_uv_fault[0] <= 1'b1;
    wait_en(0, 1'b0, 60, n);
    chk("uv off", 32'(n >= 19), 32'h1);
    rail_uv_fault[0] <= 1'b0;
    wr(`MRPS_OFF_CTRL, 32'h0);
    $display("fault test done");
  endtask

  task automatic t_auto();
    int n;
    wr(`MRPS_OFF_CTRL, 32'h2);
    wait_en(2, 1'b1, 40, n);
    chk("auto ignores pin", 32'(n >= 10), 32'h1);
    $display("auto test done");
  endtask

  initial begin
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    control_line_pin = 1'b0;
    general_input_pin = 8'h00;
    rail_uv_fault = 10'h000;
    rail_ov_fault = 10'h000;
    cascade_in = 1'b0;
    stuck = 10'h000;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_pin();
    t_op();
    t_fault();
    t_auto();
    report_and_stop();
  end
endmodule

// ==== verilog/mrps_sequencer.sv ====
// Multi-rail power sequencer: APB registers, tick, per-rail sequencers.
// Assumes rail comparator and fault inputs arrive asynchronously.
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "mrps_params.svh"

module mrps_sequencer #(
  parameter int N_RAILS     = `MRPS_NUM_RAILS,
  parameter int TICK_CYCLES = `MRPS_TICK_CYCLES
) (
  // Clock, reset, enable
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                clk_en,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Pins and rail monitors
  input  wire logic                control_line_pin,
  input  wire logic [7:0]          general_input_pin,
  input  wire logic [N_RAILS-1:0]  rail_above_on,
  input  wire logic [N_RAILS-1:0]  rail_below_off,
  input  wire logic [N_RAILS-1:0]  rail_uv_fault,
  input  wire logic [N_RAILS-1:0]  rail_ov_fault,
  input  wire logic                cascade_in,
  // Rail enables and cascade
  output logic      [N_RAILS-1:0]  rail_enable,
  output logic                     cascade_out
);

  localparam int SW = 10 + 8 + 4 * N_RAILS;

  // Clamp a delay field to the longest legal delay
  function automatic logic [11:0] sat_ms(input logic [11:0] v);
    sat_ms = (v > `MRPS_DLY_MAX_MS) ? `MRPS_DLY_MAX_MS : v;
  endfunction

  // True once a tick count has passed its limit; zero means no wait
  // Passing, not reaching, so a partial first tick never shortens it
  function automatic logic ms_done(input logic [11:0] n,
                                   input logic [11:0] lim);
    ms_done = (lim == 12'h000) || (n > lim) || (n == 12'hFFF);
  endfunction

  // True when addr selects word w of rail r
  function automatic logic rail_hit(input logic [11:0] a,
                                    input int r,
                                    input logic [1:0] w);
    rail_hit = (a[11:8] == `MRPS_RAIL_PAGE) &&
               (a[7:4] == 4'(r)) && (a[3:2] == w);
  endfunction

  // Synchroniser stages for every asynchronous input
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  wire  [SW-1:0] async_in = {cascade_in, control_line_pin,
                             general_input_pin, rail_above_on,
                             rail_below_off, rail_uv_fault,
                             rail_ov_fault, 8'h00};

  // Two-flop synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else if (clk_en) begin
      sync1 <= async_in;
      sync2 <= sync1;
    end
  end

  // Unpacked synchronised inputs
  wire               casc_s  = sync2[SW-1];
  wire               pin_s   = sync2[SW-2];
  wire [7:0]         gpi_s   = sync2[SW-3 -: 8];
  wire [N_RAILS-1:0] above_s = sync2[8+4*N_RAILS-1 -: N_RAILS];
  wire [N_RAILS-1:0] below_s = sync2[8+3*N_RAILS-1 -: N_RAILS];
  wire [N_RAILS-1:0] uv_s    = sync2[8+2*N_RAILS-1 -: N_RAILS];
  wire [N_RAILS-1:0] ov_s    = sync2[8+N_RAILS-1 -: N_RAILS];

  // Millisecond tick
  logic [16:0] tick_cnt;
  logic        tick;
  wire         tick_wrap = (tick_cnt == 17'(TICK_CYCLES - 1));

  // Free-running millisecond divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 17'h00000;
      tick     <= 1'b0;
    end else if (clk_en) begin
      tick_cnt <= tick_wrap ? 17'h00000 : tick_cnt + 17'h00001;
      tick     <= tick_wrap;
    end
  end

  // APB phase decode
  logic [2:0] ctrl;
  wire        acc     = psel & penable & ~pready;
  wire        fire    = psel & penable & pready;
  wire        glb_pg  = (paddr[11:4] == 8'h00);
  wire        rail_pg = (paddr[11:8] == `MRPS_RAIL_PAGE) &&
                        (paddr[7:4] < 4'(N_RAILS));
  wire        hit     = glb_pg | rail_pg;
  wire        wr      = fire & pwrite & ~pslverr;
  wire        wr_ctrl = wr && (paddr == `MRPS_OFF_CTRL);
  wire        wr_tonf = wr && (paddr == `MRPS_OFF_TON_FAULT);

  // APB answer: one wait state, registered outputs
  logic [31:0] rd_data;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= `MRPS_WORD_RST;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= acc;
      prdata  <= acc ? rd_data : `MRPS_WORD_RST;
      pslverr <= acc & ~hit;
    end
  end

  // Global control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `MRPS_CTRL_RST;
    end else if (clk_en && wr_ctrl) begin
      ctrl <= pwdata[2:0];
    end
  end

  // Global command terms
  wire auto_en = ctrl[`MRPS_CTRL_AUTO];
  wire op_on   = ctrl[`MRPS_CTRL_OP_ON];
  wire pin_on  = pin_s ^ ctrl[`MRPS_CTRL_PIN_LOW];

  // Per-rail register storage
  mrps_pkg::mrps_cfg_t  cfg    [N_RAILS];
  mrps_pkg::mrps_mask_t parent [N_RAILS];
  mrps_pkg::mrps_pair_t dly    [N_RAILS];
  mrps_pkg::mrps_pair_t lim    [N_RAILS];

  // Per-rail status vectors
  logic [N_RAILS-1:0] good;
  logic [N_RAILS-1:0] tonf;
  logic [N_RAILS-1:0] fault_now;
  logic [N_RAILS-1:0] foff;
  logic [N_RAILS-1:0] casc_sel;

  // Read selection
  wire [11:0] rsel = {paddr[11:2], 2'b00};
  wire [3:0]  ridx = paddr[7:4];

  // Words of the addressed rail, flattened before the select
  wire [31:0] cfg_word = cfg[ridx];
  wire [31:0] par_word = parent[ridx];
  wire [31:0] dly_word = dly[ridx];
  wire [31:0] lim_word = lim[ridx];
  wire [31:0] rail_word =
    (paddr[3:2] == `MRPS_W_CFG)    ? cfg_word :
    (paddr[3:2] == `MRPS_W_PARENT) ? par_word :
    (paddr[3:2] == `MRPS_W_DELAY)  ? dly_word : lim_word;
  assign rd_data =
    (rsel == `MRPS_OFF_CTRL)      ? {29'h0, ctrl}             :
    (rsel == `MRPS_OFF_RAIL_EN)   ? 32'(rail_enable)          :
    (rsel == `MRPS_OFF_RAIL_GOOD) ? 32'(good)                 :
    (rsel == `MRPS_OFF_TON_FAULT) ? 32'(tonf)                 :
    rail_pg                       ? rail_word : `MRPS_WORD_RST;

  // Cascade out to other controllers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cascade_out <= 1'b0;
    end else if (clk_en) begin
      cascade_out <= |(foff & casc_sel);
    end
  end

  // One sequencer per rail
  genvar i;
  generate
    for (i = 0; i < N_RAILS; i++) begin : g_rail
      mrps_pkg::mrps_state_t state;
      mrps_pkg::mrps_state_t next_state;
      logic [11:0]           cnt;
      logic [11:0]           elap;
      mrps_pkg::mrps_cfg_t   c;
      mrps_pkg::mrps_mask_t  m;

      assign c           = cfg[i];
      assign m           = parent[i];
      assign casc_sel[i] = c.casc_out;

      // Delay and limit fields
      wire [11:0] ton_dly  = dly[i].lo;
      wire [11:0] toff_dly = dly[i].hi;
      wire [11:0] ton_max  = lim[i].lo;
      wire [11:0] toff_max = lim[i].hi;

      // On-trigger terms
      wire par_on  = &(good | ~m.on_mask[N_RAILS-1:0]);
      wire gpi_on  = gpi_s[c.gpi_sel] == c.gpi_on_lvl;
      wire any_on  = auto_en | c.on_op | c.on_pin |
                     c.on_parent | c.on_gpi;
      wire cmd_on  = any_on & ~c.monitor_only &
                     (auto_en | ~c.on_op  | op_on) &
                     (auto_en | ~c.on_pin | pin_on) &
                     (~c.on_parent | par_on) &
                     (~c.on_gpi | gpi_on);

      // Off-trigger terms
      wire par_off = |(~good & m.off_mask[N_RAILS-1:0]);
      wire gpi_off = gpi_s[c.gpi_sel]
                     == c.gpi_off_lvl;
      wire go_off  = (c.off_op  & ~auto_en & ~op_on) |
                     (c.off_pin & ~auto_en & ~pin_on) |
                     (c.off_parent & par_off) |
                     (c.off_gpi & gpi_off) |
                     (c.casc_in & casc_s) |
                     foff[i];

      // Master fault seen by a slave rail
      wire mst_ok  = c.slave && (c.master < 4'(N_RAILS));
      wire mst_flt = mst_ok && fault_now[c.master];

      // Turn-on fault: good not reached within nonzero limit
      wire ton_to  = (state == mrps_pkg::st_on) && c.monitored &&
                     (ton_max != 12'h000) &&
                     ms_done(elap, ton_max) && ~good[i];
      assign fault_now[i] = (rail_enable[i] & (uv_s[i] | ov_s[i]))
                            | ton_to;

      // Sequencer next state
      always_comb begin
        next_state = state;
        case (state)
          mrps_pkg::st_off: begin
            if (cmd_on && !go_off) begin
              next_state = mrps_pkg::st_on_wait;
            end
          end
          mrps_pkg::st_on_wait: begin
            if (!cmd_on || go_off) begin
              next_state = mrps_pkg::st_off;
            end else if (ms_done(cnt, ton_dly)) begin
              next_state = mrps_pkg::st_on;
            end
          end
          mrps_pkg::st_on: begin
            if (go_off) begin
              next_state = (c.immediate || toff_dly == 12'h000)
                           ? mrps_pkg::st_off
                           : mrps_pkg::st_off_wait;
            end
          end
          mrps_pkg::st_off_wait: begin
            if (ms_done(cnt, toff_dly)) begin
              next_state = mrps_pkg::st_off;
            end
          end
          default: next_state = mrps_pkg::st_off;
        endcase
      end

      // State, delay counter and elapsed counter
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          state <= mrps_pkg::st_off;
          cnt   <= 12'h000;
          elap  <= 12'h000;
        end else if (clk_en) begin
          state <= next_state;
          if (next_state != state) begin
            cnt <= 12'h000;
          end else if (tick && cnt != 12'hFFF) begin
            cnt <= cnt + 12'h001;
          end
          // Elapsed time restarts on entering on or off
          if ((state == mrps_pkg::st_on_wait &&
               next_state == mrps_pkg::st_on) ||
              (state != mrps_pkg::st_off &&
               next_state == mrps_pkg::st_off)) begin
            elap <= 12'h000;
          end else if (tick && elap != 12'hFFF) begin
            elap <= elap + 12'h001;
          end
        end
      end

      // Enable output follows the sequencer
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rail_enable[i] <= 1'b0;
        end else if (clk_en) begin
          rail_enable[i] <= (next_state == mrps_pkg::st_on) ||
                            (next_state == mrps_pkg::st_off_wait);
        end
      end

      // Power-good tracking
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          good[i] <= 1'b0;
        end else if (clk_en) begin
          if (c.monitored) begin
            if (above_s[i]) begin
              good[i] <= 1'b1;
            end else if (below_s[i]) begin
              good[i] <= 1'b0;
            end
          end else if (state == mrps_pkg::st_on &&
                       ms_done(elap, ton_max)) begin
            good[i] <= 1'b1;
          end else if (state == mrps_pkg::st_off &&
                       ms_done(elap, toff_max)) begin
            good[i] <= 1'b0;
          end
        end
      end

      // Fault shutdown latch and turn-on fault flag
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          foff[i] <= 1'b0;
          tonf[i] <= 1'b0;
        end else if (clk_en) begin
          // Latch holds until the rail is off and unrequested
          if (fault_now[i] || mst_flt) begin
            foff[i] <= 1'b1;
          end else if (state == mrps_pkg::st_off && !cmd_on) begin
            foff[i] <= 1'b0;
          end
          if (ton_to) begin
            tonf[i] <= 1'b1;
          end else if (wr_tonf && pwdata[i]) begin
            tonf[i] <= 1'b0;
          end
        end
      end

      // Rail registers written over APB
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cfg[i]    <= `MRPS_WORD_RST;
          parent[i] <= `MRPS_WORD_RST;
          dly[i]    <= `MRPS_WORD_RST;
          lim[i]    <= `MRPS_WORD_RST;
        end else if (clk_en && wr) begin
          if (rail_hit(paddr, i, `MRPS_W_CFG)) begin
            cfg[i] <= {9'h000, pwdata[22:0]};
          end
          if (rail_hit(paddr, i, `MRPS_W_PARENT)) begin
            parent[i] <= {6'h00, pwdata[25:16], 6'h00, pwdata[9:0]};
          end
          if (rail_hit(paddr, i, `MRPS_W_DELAY)) begin
            dly[i] <= {4'h0, sat_ms(pwdata[27:16]),
                       4'h0, sat_ms(pwdata[11:0])};
          end
          if (rail_hit(paddr, i, `MRPS_W_LIMIT)) begin
            lim[i] <= {4'h0, pwdata[27:16], 4'h0, pwdata[11:0]};
          end
        end
      end
    end
  endgenerate

endmodule
